// *** core/pwd_defines.vh ***
// Constants for the dual PWM to DAC code converter
`ifndef PWD_DEFINES_VH
`define PWD_DEFINES_VH
`define PWD_CLK_MHZ       10
`define PWD_T_CMP_NS      3200
`define PWD_CMP_CYC       ((`PWD_T_CMP_NS * `PWD_CLK_MHZ) / 1000)
`define PWD_T_IDLE_US     60000
`define PWD_IDLE_CYC      (`PWD_T_IDLE_US * `PWD_CLK_MHZ)
`define PWD_T_MINH_NS     25
`define PWD_T_MINL_NS     25
`define PWD_MINH_CYC      ((`PWD_T_MINH_NS * `PWD_CLK_MHZ + 999) / 1000)
`define PWD_MINL_CYC      ((`PWD_T_MINL_NS * `PWD_CLK_MHZ + 999) / 1000)
`define PWD_CNT_W         20
`define PWD_CODE_W        12
`define PWD_ADDR_CTRL     8'h00
`define PWD_ADDR_STATUS   8'h04
`define PWD_ADDR_CODE     8'h08
`define PWD_CTRL_RES_RST  2'h0
`define PWD_RES_12        2'h0
`define PWD_RES_10        2'h1
`define PWD_BOOT_RST      2'h3
`endif

// *** core/pwd_top.v ***
// Dual PWM duty cycle to DAC code converter with AHB-Lite status access
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
`include "pwd_defines.vh"
// Contract
// - Each channel updates only from its own input's rising edges.
// - Duty cycle comes from high and low time of the finished period.
// - Code is 2^N times high time over rising edge interval.
// - High time used belongs to the preceding period.
// - Computation starts at the rising edge itself.
// - New code loads 3.2 us after the triggering edge.
// - Output after an edge reflects the previous period's duty cycle.
// - No rising edge for the idle timeout puts channel idle.
// - Idle result depends on idle strap and input level.
// - After reset channels start zero-scale or powered down per strap.
// - Sleep low powers down both channels; high restores operation.
// - Reference strap picks internal or external reference only.
// - Period shorter than compute delay skips the update.
// - Too narrow high gives zero-scale; too narrow low gives full-scale.
// - Edge pair beyond idle timeout is ignored, code kept.
// - Sample/hold after sleep stays off until edges update the channel; with idle strap low the idle timeout turns it on without edges.
module pwd_top #(
	parameter IDLE_CYC = `PWD_IDLE_CYC
) (
	input  wire                   core_clk,
	input  wire                   nrst,
	input  wire                   hsel,
	input  wire [31:0]            haddr,
	input  wire [1:0]             htrans,
	input  wire                   hwrite,
	input  wire [2:0]             hsize,
	input  wire [31:0]            hwdata,
	input  wire                   hready,
	output wire                   hreadyout,
	output wire [31:0]            hrdata,
	output wire                   hresp,
	input  wire                   pwm_input_a,
	input  wire                   pwm_input_b,
	input  wire                   idle_behaviour_strap,
	input  wire                   reference_source_strap,
	input  wire                   sleep_n,
	output wire [`PWD_CODE_W-1:0] dac_code_a,
	output wire [`PWD_CODE_W-1:0] dac_code_b,
	output wire                   dac_on_a,
	output wire                   dac_on_b,
	output wire                   ref_external,
	output wire                   ref_internal_on
);
	localparam CW = `PWD_CNT_W;
	localparam DW = `PWD_CODE_W;
	localparam [CW-1:0] IDLE_C = IDLE_CYC;
	localparam [CW-1:0] CMP_C  = `PWD_CMP_CYC;
	localparam [CW-1:0] MINH_C = `PWD_MINH_CYC;
	localparam [CW-1:0] MINL_C = `PWD_MINL_CYC;
	localparam [CW-1:0] SAT_C  = {CW{1'b1}};

	// Full-scale code at the selected resolution
	function [DW-1:0] pwd_full;
		input [1:0] res;
		begin
			if (res == `PWD_RES_12)
				pwd_full = 12'hFFF;
			else if (res == `PWD_RES_10)
				pwd_full = 12'h3FF;
			else
				pwd_full = 12'h0FF;
		end
	endfunction

	// Twelve quotient bits reduced to the selected resolution
	function [DW-1:0] pwd_scale;
		input [DW-1:0] quo;
		input [1:0]    res;
		begin
			if (res == `PWD_RES_12)
				pwd_scale = quo;
			else if (res == `PWD_RES_10)
				pwd_scale = {2'h0, quo[11:2]};
			else
				pwd_scale = {4'h0, quo[11:4]};
		end
	endfunction

	reg         sl_s1_q;
	reg         sl_s2_q;
	reg         is_s1_q;
	reg         is_s2_q;
	reg         rs_s1_q;
	reg         rs_s2_q;
	reg  [1:0]  boot_q;
	reg         run_q;
	reg         fullpd_q;
	reg         ref_on_q;
	reg  [1:0]  ctrl_res_q;
	reg         hrdy_q;
	reg  [31:0] hrdata_q;
	reg         wr_q;
	reg  [7:0]  waddr_q;
	wire [1:0]  pin_w;
	wire [1:0]  rise_w;
	wire [1:0]  pd_w;
	wire [1:0]  idle_w;
	wire [1:0]  lvl_w;
	wire [2*DW-1:0] code_w;
	wire        boot_p;

	assign pin_w  = {pwm_input_b, pwm_input_a};
	assign boot_p = (boot_q == 2'h1);

	// Straps and sleep are pins: two flops before use
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sl_s1_q  <= 1'b0;
			sl_s2_q  <= 1'b0;
			is_s1_q  <= 1'b0;
			is_s2_q  <= 1'b0;
			rs_s1_q  <= 1'b0;
			rs_s2_q  <= 1'b0;
			boot_q   <= `PWD_BOOT_RST;
			run_q    <= 1'b0;
			fullpd_q <= 1'b1;
			ref_on_q <= 1'b0;
		end
		else
		begin
			sl_s1_q <= sleep_n;
			sl_s2_q <= sl_s1_q;
			is_s1_q <= idle_behaviour_strap;
			is_s2_q <= is_s1_q;
			rs_s1_q <= reference_source_strap;
			rs_s2_q <= rs_s1_q;
			if (boot_q != 2'h0)
				boot_q <= boot_q - 2'h1;
			if (boot_p)
				run_q <= 1'b1;
			if (!sl_s2_q || boot_p)
				fullpd_q <= 1'b1;
			else if (run_q && (!is_s2_q || (rise_w != 2'h0)))
				fullpd_q <= 1'b0;
			// Reference choice only gates the internal reference power
			ref_on_q <= run_q && sl_s2_q && !fullpd_q && !rs_s2_q
				&& (pd_w != 2'h3);
		end
	end

	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1)
		begin : ch
			reg          s1_q;
			reg          s2_q;
			reg          lvl_q;
			reg [CW-1:0] per_q;
			reg [CW-1:0] hi_q;
			reg          seen_q;
			reg          idle_q;
			reg          pd_q;
			reg [DW-1:0] code_q;
			reg          busy_q;
			reg [CW-1:0] dly_q;
			reg [CW-1:0] rem_q;
			reg [CW-1:0] div_q;
			reg [DW-1:0] quo_q;
			reg [3:0]    step_q;
			reg          zs_q;
			reg          fs_q;
			wire         rise;
			wire [CW:0]  trial;

			assign rise  = s2_q && !lvl_q;
			assign trial = {rem_q, 1'b0};
			assign rise_w[i] = rise && run_q && sl_s2_q;
			assign pd_w[i]   = pd_q;
			assign idle_w[i] = idle_q;
			assign lvl_w[i]  = lvl_q;
			assign code_w[i*DW +: DW] = code_q;

			always @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
				begin
					s1_q   <= 1'b0;
					s2_q   <= 1'b0;
					lvl_q  <= 1'b0;
					per_q  <= {CW{1'b0}};
					hi_q   <= {CW{1'b0}};
					seen_q <= 1'b0;
					idle_q <= 1'b0;
					pd_q   <= 1'b1;
					code_q <= {DW{1'b0}};
					busy_q <= 1'b0;
					dly_q  <= {CW{1'b0}};
					rem_q  <= {CW{1'b0}};
					div_q  <= {CW{1'b0}};
					quo_q  <= {DW{1'b0}};
					step_q <= 4'h0;
					zs_q   <= 1'b0;
					fs_q   <= 1'b0;
				end
				else
				begin
					s1_q  <= pin_w[i];
					s2_q  <= s1_q;
					lvl_q <= s2_q;
					// Saturating counters reach past the idle timeout
					if (per_q != SAT_C)
						per_q <= per_q + 1'b1;
					if (s2_q && (hi_q != SAT_C))
						hi_q <= hi_q + 1'b1;
					if (boot_p)
					begin
						pd_q   <= is_s2_q;
						code_q <= {DW{1'b0}};
					end
					else if (!run_q || !sl_s2_q)
					begin
						pd_q   <= 1'b1;
						seen_q <= 1'b0;
						busy_q <= 1'b0;
						idle_q <= 1'b0;
					end
					else
					begin
						if (rise)
						begin
							per_q  <= {{(CW-1){1'b0}}, 1'b1};
							hi_q   <= {{(CW-1){1'b0}}, 1'b1};
							idle_q <= 1'b0;
							seen_q <= 1'b1;
							// Needs a valid previous edge and no timeout between
							if (seen_q && !idle_q && (per_q >= CMP_C))
							begin
								busy_q <= 1'b1;
								dly_q  <= CMP_C - 1'b1;
								rem_q  <= hi_q;
								div_q  <= per_q;
								quo_q  <= {DW{1'b0}};
								step_q <= 4'hC;
								zs_q   <= (hi_q < MINH_C);
								fs_q   <= ((per_q - hi_q) < MINL_C) || (hi_q >= per_q);
							end
						end
						else if (!idle_q && (per_q >= IDLE_C))
						begin
							idle_q <= 1'b1;
							seen_q <= 1'b0;
						end
						if (idle_q)
						begin
							// Level may change while idle: strap low follows it, strap high only powers down on low
							if (!is_s2_q)
							begin
								pd_q   <= 1'b0;
								code_q <= lvl_q ? pwd_full(ctrl_res_q) : {DW{1'b0}};
							end
							else if (!lvl_q)
								pd_q <= 1'b1;
						end
						else if (!is_s2_q && fullpd_q == 1'b0 && pd_q && !seen_q)
							pd_q <= 1'b1;
						if (busy_q && !rise)
						begin
							if (step_q != 4'h0)
							begin
								// Restoring long division, one quotient bit a cycle
								if (trial >= {1'b0, div_q})
								begin
									rem_q <= trial[CW-1:0] - div_q;
									quo_q <= {quo_q[DW-2:0], 1'b1};
								end
								else
								begin
									rem_q <= trial[CW-1:0];
									quo_q <= {quo_q[DW-2:0], 1'b0};
								end
								step_q <= step_q - 4'h1;
							end
							if (dly_q != {CW{1'b0}})
								dly_q <= dly_q - 1'b1;
							else
							begin
								busy_q <= 1'b0;
								pd_q   <= 1'b0;
								if (zs_q)
									code_q <= {DW{1'b0}};
								else if (fs_q)
									code_q <= pwd_full(ctrl_res_q);
								else
									code_q <= pwd_scale(quo_q, ctrl_res_q);
							end
						end
					end
				end
			end
		end
	endgenerate

	// Zero wait state slave; read data prepared in the address phase
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			hrdy_q     <= 1'b1;
			hrdata_q   <= 32'h00000000;
			wr_q       <= 1'b0;
			waddr_q    <= 8'h00;
			ctrl_res_q <= `PWD_CTRL_RES_RST;
		end
		else
		begin
			hrdy_q <= 1'b1;
			wr_q   <= hsel && hready && htrans[1] && hwrite;
			if (hsel && hready && htrans[1])
				waddr_q <= haddr[7:0];
			if (wr_q && (waddr_q == `PWD_ADDR_CTRL))
				ctrl_res_q <= hwdata[1:0];
			if (hsel && hready && htrans[1] && !hwrite)
			begin
				case (haddr[7:0])
					`PWD_ADDR_CTRL:
						hrdata_q <= {30'h00000000, ctrl_res_q};
					`PWD_ADDR_STATUS:
						hrdata_q <= {23'h000000, rs_s2_q, is_s2_q, fullpd_q,
							idle_w, pd_w, lvl_w};
					`PWD_ADDR_CODE:
						hrdata_q <= {4'h0, code_w[2*DW-1:DW], 4'h0, code_w[DW-1:0]};
					default:
						hrdata_q <= 32'h00000000;
				endcase
			end
		end
	end

	assign hreadyout       = hrdy_q;
	assign hrdata          = hrdata_q;
	assign hresp           = 1'b0;
	assign dac_code_a      = ch[0].code_q;
	assign dac_code_b      = ch[1].code_q;
	assign dac_on_a        = !ch[0].pd_q;
	assign dac_on_b        = !ch[1].pd_q;
	assign ref_external    = rs_s2_q;
	assign ref_internal_on = ref_on_q;
endmodule // pwd_top

// *** dv/pwd_top_assertions.sv ***
// Port-level assertions for the dual PWM to DAC code converter
`timescale 1ns/10ps
module pwd_top_assertions (
	input wire		core_clk,
	input wire		nrst,
	input wire		hreadyout,
	input wire		hresp,
	input wire		pwm_input_a,
	input wire		idle_behaviour_strap,
	input wire		reference_source_strap,
	input wire		sleep_n,
	input wire [11:0]	dac_code_a,
	input wire		dac_on_a,
	input wire		dac_on_b,
	input wire		ref_external,
	input wire		ref_internal_on
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout dropped");
	a_resp_okay: assert property (!hresp)
		else $error("error response seen");
	a_por_on: assert property ($rose(nrst) && !idle_behaviour_strap |-> ##4
		dac_on_a && dac_on_b && dac_code_a == 12'h000) else $error("bad zero-scale start");
	a_por_off: assert property ($rose(nrst) && idle_behaviour_strap |-> ##4
		!dac_on_a && !dac_on_b) else $error("bad powered-down start");
	a_sleep_off: assert property (!sleep_n [*5] |=>
		!dac_on_a && !dac_on_b && !ref_internal_on) else $error("sleep ignored");
	a_ref_follow: assert property ($stable(reference_source_strap) [*5] |->
		ref_external == reference_source_strap) else $error("reference select lost");
	a_ref_int_off: assert property (ref_external [*2] |-> !ref_internal_on)
		else $error("internal reference left powered");
	// A load this early would mean the delay was not honoured
	a_code_hold: assert property ($rose(pwm_input_a) && sleep_n |=>
		$stable(dac_code_a) [*8]) else $error("code changed too soon");
endmodule // pwd_top_assertions
bind pwd_top pwd_top_assertions u_chk (.*);

// *** dv/pwd_pwm_src.sv ***
// PWM source model standing in for the external timer
`timescale 1ns/10ps
module pwd_pwm_src (
	input wire		clk,
	input wire		en,
	input wire		lvl,
	input wire [7:0]	hi,
	input wire [7:0]	per,
	output logic		pwm
);
	logic [7:0]	cnt_q = 8'h00;
	logic [7:0]	per_q = 8'h01;
	logic [7:0]	hi_q;
	initial pwm = 1'b0;
	// New widths latch at a period boundary so no odd period is sent
	always @(posedge clk)
	begin
		if (!en || cnt_q == per_q - 8'h01)
		begin
			cnt_q <= 8'h00;
			hi_q <= hi;
			per_q <= per;
			pwm <= en | lvl;
		end
		else
		begin
			cnt_q <= cnt_q + 8'h01;
			pwm <= cnt_q + 8'h01 < hi_q;
		end
	end
endmodule // pwd_pwm_src

// *** dv/dual_pwm_to_dac_code_test.sv ***
// Self-checking bench for the dual PWM to DAC code converter
`timescale 1ns/10ps
`define CHK(g, e) \
begin \
	checks_done++; \
	if ((g) !== (e)) \
	begin \
		bad_count++; \
		$display("CHECK FAILED %0t got %h exp %h", $time, g, e); \
	end \
end
module dual_pwm_to_dac_code_test;
	logic		core_clk, nrst, hsel, hwrite, hreadyout, hresp, sleep_n, en_a, lvl_a, en_b;
	logic		idle_behaviour_strap, reference_source_strap, pwm_input_a, pwm_input_b;
	logic		dac_on_a, dac_on_b, ref_external, ref_internal_on;
	logic [1:0]	htrans;
	logic [2:0]	hsize;
	logic [7:0]	hi_a, per_a;
	logic [11:0]	dac_code_a, dac_code_b;
	logic [31:0]	haddr, hwdata, hrdata, rd;
	int		bad_count = 0;
	int		checks_done = 0;
	pwd_top #(.IDLE_CYC(2000)) uut (.hready(hreadyout), .*);
	pwd_pwm_src src_a (.clk(core_clk), .en(en_a), .lvl(lvl_a), .hi(hi_a), .per(per_a),
		.pwm(pwm_input_a));
	// Channel B keeps a steady three-quarter duty throughout
	pwd_pwm_src src_b (.clk(core_clk), .en(en_b), .lvl(1'b0), .hi(8'h1E), .per(8'h28),
		.pwm(pwm_input_b));
	task automatic wait_clk(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		hsize <= 3'h2;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		#1;
	endtask
	task automatic do_reset;
		nrst = 1'b0;
		wait_clk(6);
		nrst = 1'b1;
		wait_clk(5);
	endtask
	task automatic stop_test;
		if (bad_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic t_duty;
		for (int r = 0; r < 3; r++)
		begin
			ahb(8'h00, 1'b1, r);
			wait_clk(200);
			`CHK(dac_code_a, 12'h400 >> 2 * r)
			ahb(8'h08, 1'b0, 32'h0);
			`CHK(rd, {4'h0, 12'hC00 >> 2 * r, 4'h0, 12'h400 >> 2 * r})
		end
		ahb(8'h00, 1'b1, 32'h0);
		ahb(8'h10, 1'b0, 32'h0);
		`CHK(rd, 32'h0)
	endtask
	task automatic t_delay;
		hi_a = 8'h14;
		@(posedge pwm_input_a);
		@(posedge pwm_input_a);
		wait_clk(34);
		`CHK(dac_code_a, 12'h400)
		wait_clk(2);
		`CHK(dac_code_a, 12'h800)
		hi_a = 8'h05;
		per_a = 8'h14;
		wait_clk(300);
		`CHK(dac_code_a, 12'h800)
	endtask
	task automatic t_idle;
		en_a = 1'b0;
		wait_clk(1800);
		`CHK(dac_code_a, 12'h800)
		wait_clk(400);
		`CHK({dac_on_a, dac_code_a}, {1'b1, 12'h000})
		// Only channel A idle, straps low, both channels powered
		ahb(8'h04, 1'b0, 32'h0);
		`CHK(rd[8:2], 7'h04)
		lvl_a = 1'b1;
		wait_clk(2200);
		`CHK({dac_on_a, dac_code_a}, {1'b1, 12'hFFF})
		`CHK(dac_code_b, 12'hC00)
	endtask
	task automatic t_sleep;
		sleep_n = 1'b0;
		wait_clk(10);
		`CHK({dac_on_a, dac_on_b, ref_internal_on}, 3'h0)
		sleep_n = 1'b1;
		reference_source_strap = 1'b1;
		wait_clk(200);
		`CHK({dac_on_b, ref_external, ref_internal_on, dac_code_b}, {3'h6, 12'hC00})
	endtask
	task automatic t_hold;
		nrst = 1'b0;
		idle_behaviour_strap = 1'b1;
		lvl_a = 1'b0;
		do_reset;
		`CHK({dac_on_a, dac_on_b}, 2'h0)
		en_a = 1'b1;
		hi_a = 8'h0A;
		per_a = 8'h28;
		wait_clk(300);
		`CHK({dac_on_a, dac_on_b, dac_code_a}, {2'h3, 12'h400})
		@(posedge pwm_input_a);
		en_a = 1'b0;
		lvl_a = 1'b1;
		wait_clk(2200);
		`CHK({dac_on_a, dac_code_a}, {1'b1, 12'h400})
		lvl_a = 1'b0;
		wait_clk(2200);
		`CHK(dac_on_a, 1'b0)
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial
	begin
		#3000000;
		bad_count++;
		stop_test;
	end
	initial
	begin
		nrst = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		hsize = 3'h0;
		en_b = 1'b1;
		idle_behaviour_strap = 1'b0;
		reference_source_strap = 1'b0;
		sleep_n = 1'b1;
		en_a = 1'b1;
		lvl_a = 1'b0;
		hi_a = 8'h0A;
		per_a = 8'h28;
		do_reset;
		t_duty;
		t_delay;
		t_idle;
		t_sleep;
		t_hold;
		stop_test;
	end
endmodule // dual_pwm_to_dac_code_test
